// >>> hdl/pmr_pkg.sv
// Constants and types for the attachment-layer management register bank
package pmr_pkg;
   // Management device and register addresses
   localparam logic [4:0]  MMD_PMA        = 5'h01;
   localparam logic [15:0] REG_CTRL_ONE   = 16'h0000;
   localparam logic [15:0] REG_STAT_ONE   = 16'h0001;
   localparam logic [15:0] REG_DEVS_LOW   = 16'h0005;
   localparam logic [15:0] REG_DEVS_HIGH  = 16'h0006;
   localparam logic [15:0] REG_CTRL_TWO   = 16'h0007;
   // Field positions
   localparam int          CTRL_RST_BIT   = 15;
   localparam int          CTRL_PD_BIT    = 11;
   localparam int          CTRL_LB_BIT    = 0;
   localparam int          STAT_LINK_BIT  = 2;
   localparam int          STAT_PDCAP_BIT = 1;
   // Reset and constant values
   localparam logic [15:0] CTRL_ONE_RST   = 16'h0000;
   localparam logic [15:0] STAT_ONE_RST   = 16'h0002;
   localparam logic [15:0] DEVS_LOW_VAL   = 16'h008B;
   localparam logic [15:0] DEVS_HIGH_VAL  = 16'hC000;
   localparam logic [6:0]  CTRL_TWO_RST   = 7'h3D;
   // Frame layout
   localparam logic [5:0]  PREAMBLE_ONES  = 6'h20;
   localparam logic [4:0]  HDR_LAST       = 5'h0C;
   localparam logic [4:0]  TA_LAST        = 5'h01;
   localparam logic [4:0]  DATA_LAST      = 5'h0F;
   localparam logic [1:0]  OP_ADDR        = 2'h0;
   localparam logic [1:0]  OP_WRITE       = 2'h1;
   localparam logic [1:0]  OP_RDINC       = 2'h2;
   localparam logic [1:0]  OP_READ        = 2'h3;
   // Soft reset duration
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          SOFT_RST_NS    = 10000;
   localparam int          SOFT_RST_CYC   = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0]  SOFT_RST_LAST  = 10'(SOFT_RST_CYC - 1);

   typedef enum logic [1:0] {
      ST_PRE  = 2'b00,
      ST_HDR  = 2'b01,
      ST_TA   = 2'b11,
      ST_DATA = 2'b10
   } pmr_state_e;
endpackage : pmr_pkg

// >>> hdl/pmr_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
module pmr_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1;

   // No reset: the pin level is valid two edges after any edge
   always_ff @(posedge sys_clk) begin
      stage1 <= din;
      dout   <= stage1;
   end
endmodule : pmr_sync

// >>> hdl/pmr_rst_seq.sv
// Timer that holds the chip soft reset busy for a fixed duration
module pmr_rst_seq
   import pmr_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic start,
   output logic      busy
);
   logic [9:0] cnt;
   logic [9:0] next_cnt;
   logic       next_busy;

   always_comb begin
      next_cnt  = cnt;
      next_busy = busy;
      if (start && !busy) begin
         next_busy = 1'b1;
         next_cnt  = '0;
      end else if (busy) begin
         if (cnt == SOFT_RST_LAST) begin
            next_busy = 1'b0;
         end else begin
            next_cnt = cnt + 10'h001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cnt  <= '0;
         busy <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         busy <= next_busy;
      end
   end

   // Separate busy length count, so the check does not lean on the timer itself
   logic [10:0] busy_len;
   logic [10:0] next_busy_len;

   always_comb begin
      next_busy_len = busy ? busy_len + 11'h001 : 11'h000;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         busy_len <= 11'h000;
      end else begin
         busy_len <= next_busy_len;
      end
   end

   property p_rst_self_clear;
      @(posedge sys_clk) disable iff (!rst_b)
         (busy |-> busy_len < 11'(SOFT_RST_CYC))
         and ($fell(busy) |-> busy_len == 11'(SOFT_RST_CYC));
   endproperty
   a_rst_self_clear: assert property (p_rst_self_clear) else $error("soft reset did not clear");
endmodule : pmr_rst_seq

// >>> hdl/pmr_regs.sv
// Attachment-layer management registers behind a Clause 45 management slave
//
// Summary of operation
// - Control bit 15 write starts chip reinitialisation
// - Soft reset bit self-clears, reads 1 while busy
// - Control bit 11 enters soft power-down
// - Management access stays live during power-down
// - Power-down default comes from strap pin
// - Control one resets to zero plus strap
// - Bit 0 loops transmit data onto receive
// - Status bit 2 latches low on link loss
// - Status bit 1 always one; status resets 0x0002
// - Register 5 reads constant 0x8B
// - Register 6 reads constant 0xC000
// - Control two at 7, resets 0x3D
// - Bank answers Clause 45 device 0x01 only
module pmr_regs
   import pmr_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output logic            mdio_out,
   output logic            mdio_oe_b,
   input  wire logic [4:0] port_addr,
   input  wire logic       power_down_strap_pin,
   input  wire logic       link_ok,
   input  wire logic [3:0] tx_nibble,
   input  wire logic [3:0] line_rx_nibble,
   output logic      [3:0] rx_nibble,
   output logic            soft_power_down,
   output logic            local_loopback_enable,
   output logic      [6:0] attachment_type_select,
   output logic            chip_reset_active
);
   logic       mdc_s;
   logic       mdio_s;
   logic       strap_s;
   logic [4:0] port_s;
   logic       mdc_d;
   logic       rise;

   pmr_sync #(.W(8)) u_sync (
      .sys_clk (sys_clk),
      .din     ({mdc, mdio_in, power_down_strap_pin, port_addr}),
      .dout    ({mdc_s, mdio_s, strap_s, port_s})
   );

   logic rst_start;

   pmr_rst_seq u_rst_seq (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .start   (rst_start),
      .busy    (chip_reset_active)
   );

   pmr_state_e  state;
   pmr_state_e  next_state;
   logic [4:0]  bit_cnt;
   logic [4:0]  next_bit_cnt;
   logic [5:0]  ones_cnt;
   logic [5:0]  next_ones_cnt;
   logic [11:0] hdr_sr;
   logic [11:0] next_hdr_sr;
   logic [1:0]  op;
   logic [1:0]  next_op;
   logic        hit;
   logic        next_hit;
   logic [15:0] data_sr;
   logic [15:0] next_data_sr;
   logic [15:0] mmd_addr;
   logic [15:0] next_mmd_addr;
   logic        next_mdio_out;
   logic        next_mdio_oe_b;
   logic        next_soft_pd;
   logic        next_loopback;
   logic [6:0]  next_type_sel;
   logic        link_latch;
   logic        next_link_latch;
   logic        strap_pending;
   logic        next_strap_pending;
   logic [3:0]  next_rx_nibble;
   logic [12:0] full_hdr;
   logic [15:0] full_word;
   logic [15:0] rd_word;
   logic        hit_now;
   logic        rd_op;
   logic        stat_rd_hdr;

   assign rise      = mdc_s & ~mdc_d;
   assign full_hdr  = {hdr_sr, mdio_s};
   assign full_word = {data_sr[14:0], mdio_s};
   assign rd_op     = op[1];
   // Only our device code with Clause 45 start answers
   assign hit_now   = !full_hdr[12] && (full_hdr[9:5] == port_s) && (full_hdr[4:0] == MMD_PMA);
   // Last header bit of a status read: the link latch reloads here
   assign stat_rd_hdr = rise && state == ST_HDR && bit_cnt == HDR_LAST && hit_now && full_hdr[11]
                        && mmd_addr == REG_STAT_ONE;

   // Read-back mux; reserved and unmapped read as zero
   always_comb begin
      rd_word = '0;
      unique case (mmd_addr)
         REG_CTRL_ONE: begin
            rd_word[CTRL_RST_BIT] = chip_reset_active;
            rd_word[CTRL_PD_BIT]  = soft_power_down;
            rd_word[CTRL_LB_BIT]  = local_loopback_enable;
         end
         REG_STAT_ONE: begin
            rd_word                 = STAT_ONE_RST;
            rd_word[STAT_LINK_BIT]  = link_latch;
         end
         REG_DEVS_LOW:  rd_word = DEVS_LOW_VAL;
         REG_DEVS_HIGH: rd_word = DEVS_HIGH_VAL;
         REG_CTRL_TWO:  rd_word = {9'h000, attachment_type_select};
         default:       rd_word = '0;
      endcase
   end

   always_comb begin
      next_state         = state;
      next_bit_cnt       = bit_cnt;
      next_ones_cnt      = ones_cnt;
      next_hdr_sr        = hdr_sr;
      next_op            = op;
      next_hit           = hit;
      next_data_sr       = data_sr;
      next_mmd_addr      = mmd_addr;
      next_mdio_out      = mdio_out;
      next_mdio_oe_b     = mdio_oe_b;
      next_soft_pd       = soft_power_down;
      next_loopback      = local_loopback_enable;
      next_type_sel      = attachment_type_select;
      next_strap_pending = strap_pending;
      rst_start          = 1'b0;
      // Latches low; a loss in the read cycle still reads 0 next time
      next_link_latch    = link_latch & link_ok;
      // Power-down gates the receive path, not the management slave
      if (soft_power_down) begin
         next_rx_nibble = 4'h0;
      end else if (local_loopback_enable) begin
         next_rx_nibble = tx_nibble;
      end else begin
         next_rx_nibble = line_rx_nibble;
      end
      if (rise) begin
         unique case (state)
            ST_PRE: begin
               if (mdio_s) begin
                  if (ones_cnt != PREAMBLE_ONES) begin
                     next_ones_cnt = ones_cnt + 6'h01;
                  end
               end else if (ones_cnt == PREAMBLE_ONES) begin
                  next_state    = ST_HDR;
                  next_bit_cnt  = '0;
                  next_ones_cnt = '0;
               end else begin
                  next_ones_cnt = '0;
               end
            end
            ST_HDR: begin
               next_hdr_sr  = full_hdr[11:0];
               next_bit_cnt = bit_cnt + 5'h01;
               if (bit_cnt == HDR_LAST) begin
                  next_bit_cnt = '0;
                  next_op      = full_hdr[11:10];
                  next_hit     = hit_now;
                  next_data_sr = rd_word;
                  next_state   = full_hdr[12] ? ST_PRE : ST_TA;
                  if (hit_now && full_hdr[11] && mmd_addr == REG_STAT_ONE) begin
                     next_link_latch = link_ok;
                  end
               end
            end
            ST_TA: begin
               next_bit_cnt = bit_cnt + 5'h01;
               if (hit && rd_op) begin
                  next_mdio_oe_b = 1'b0;
                  next_mdio_out  = 1'b0;
               end
               if (bit_cnt == TA_LAST) begin
                  next_state   = ST_DATA;
                  next_bit_cnt = '0;
                  if (hit && rd_op) begin
                     next_mdio_out = data_sr[15];
                     next_data_sr  = {data_sr[14:0], 1'b0};
                  end
               end
            end
            ST_DATA: begin
               next_bit_cnt = bit_cnt + 5'h01;
               if (hit && rd_op) begin
                  next_mdio_out = data_sr[15];
                  next_data_sr  = {data_sr[14:0], 1'b0};
               end else begin
                  next_data_sr = full_word;
               end
               if (bit_cnt == DATA_LAST) begin
                  next_state     = ST_PRE;
                  next_bit_cnt   = '0;
                  next_mdio_oe_b = 1'b1;
                  next_mdio_out  = 1'b1;
                  if (hit) begin
                     unique case (op)
                        OP_ADDR:  next_mmd_addr = full_word;
                        OP_RDINC: next_mmd_addr = mmd_addr + 16'h0001;
                        OP_READ:  next_mmd_addr = mmd_addr;
                        OP_WRITE: begin
                           if (mmd_addr == REG_CTRL_ONE) begin
                              rst_start     = full_word[CTRL_RST_BIT];
                              next_soft_pd  = full_word[CTRL_PD_BIT];
                              next_loopback = full_word[CTRL_LB_BIT];
                           end
                           if (mmd_addr == REG_CTRL_TWO) begin
                              next_type_sel = full_word[6:0];
                           end
                        end
                     endcase
                  end
               end
            end
         endcase
      end
      // Soft reset returns control state to defaults and re-reads the strap
      if (chip_reset_active) begin
         next_loopback      = 1'b0;
         next_type_sel      = CTRL_TWO_RST;
         next_strap_pending = 1'b1;
      end else if (strap_pending) begin
         next_soft_pd       = strap_s;
         next_strap_pending = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state                  <= ST_PRE;
         bit_cnt                <= '0;
         ones_cnt               <= '0;
         hdr_sr                 <= '0;
         op                     <= OP_ADDR;
         hit                    <= 1'b0;
         data_sr                <= '0;
         mmd_addr               <= REG_CTRL_ONE;
         mdio_out               <= 1'b1;
         mdio_oe_b              <= 1'b1;
         soft_power_down        <= CTRL_ONE_RST[CTRL_PD_BIT];
         local_loopback_enable  <= CTRL_ONE_RST[CTRL_LB_BIT];
         attachment_type_select <= CTRL_TWO_RST;
         link_latch             <= STAT_ONE_RST[STAT_LINK_BIT];
         strap_pending          <= 1'b1;
         rx_nibble              <= 4'h0;
         mdc_d                  <= 1'b0;
      end else begin
         state                  <= next_state;
         bit_cnt                <= next_bit_cnt;
         ones_cnt               <= next_ones_cnt;
         hdr_sr                 <= next_hdr_sr;
         op                     <= next_op;
         hit                    <= next_hit;
         data_sr                <= next_data_sr;
         mmd_addr               <= next_mmd_addr;
         mdio_out               <= next_mdio_out;
         mdio_oe_b              <= next_mdio_oe_b;
         soft_power_down        <= next_soft_pd;
         local_loopback_enable  <= next_loopback;
         attachment_type_select <= next_type_sel;
         link_latch             <= next_link_latch;
         strap_pending          <= next_strap_pending;
         rx_nibble              <= next_rx_nibble;
         mdc_d                  <= mdc_s;
      end
   end

   // Checks
   sequence s_ctrl_write;
      rise && state == ST_DATA && bit_cnt == DATA_LAST && hit && op == OP_WRITE && mmd_addr == REG_CTRL_ONE;
   endsequence

   sequence s_read_ta;
      rise && state == ST_TA && hit && rd_op;
   endsequence

   property p_rst_start;
      @(posedge sys_clk) disable iff (!rst_b)
         s_ctrl_write ##0 full_word[CTRL_RST_BIT] && !chip_reset_active |=> chip_reset_active [*8];
   endproperty
   a_rst_start: assert property (p_rst_start) else $error("soft reset did not start");

   property p_pd_write;
      @(posedge sys_clk) disable iff (!rst_b)
         s_ctrl_write ##0 !chip_reset_active && !strap_pending |=> soft_power_down == $past(full_word[CTRL_PD_BIT]);
   endproperty
   a_pd_write: assert property (p_pd_write) else $error("power-down bit not written");

   property p_read_in_pd;
      @(posedge sys_clk) disable iff (!rst_b)
         s_read_ta ##0 bit_cnt == 5'h00 |=> !mdio_oe_b && !mdio_out;
   endproperty
   a_read_in_pd: assert property (p_read_in_pd) else $error("turnaround not driven");

   property p_strap;
      @(posedge sys_clk) disable iff (!rst_b)
         strap_pending && !chip_reset_active |=> soft_power_down == $past(strap_s) && !strap_pending;
   endproperty
   a_strap: assert property (p_strap) else $error("strap not captured");

   property p_loopback;
      @(posedge sys_clk) disable iff (!rst_b)
         local_loopback_enable && !soft_power_down |=> rx_nibble == $past(tx_nibble);
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback data mismatch");

   property p_link_low;
      @(posedge sys_clk) disable iff (!rst_b)
         !link_ok |=> !link_latch ##1 (!link_latch || $past(stat_rd_hdr));
   endproperty
   a_link_low: assert property (p_link_low) else $error("link drop not latched");

   property p_link_relearn;
      @(posedge sys_clk) disable iff (!rst_b)
         stat_rd_hdr && link_ok |=> link_latch;
   endproperty
   a_link_relearn: assert property (p_link_relearn) else $error("link bit not refreshed");

   property p_consts;
      @(posedge sys_clk) disable iff (!rst_b)
         (mmd_addr == REG_STAT_ONE |-> rd_word[STAT_PDCAP_BIT] && rd_word[15:3] == 13'h0000)
         and (mmd_addr == REG_DEVS_LOW |-> rd_word == 16'h008B)
         and (mmd_addr == REG_DEVS_HIGH |-> rd_word == 16'hC000);
   endproperty
   a_consts: assert property (p_consts) else $error("constant register wrong");

   property p_type_reset;
      @(posedge sys_clk) !rst_b |=> attachment_type_select == 7'h3D && !local_loopback_enable;
   endproperty
   a_type_reset: assert property (p_type_reset) else $error("control two reset wrong");
endmodule : pmr_regs

// >>> sim/pmr_host.sv
// Management station model that clocks Clause 45 frames onto mdc and mdio
module pmr_host
   import pmr_pkg::*;
#(
   parameter int HALF = 6
) (
   input  wire logic       sys_clk,
   input  wire logic [4:0] prtad,
   input  wire logic       mdio_out,
   input  wire logic       mdio_oe_b,
   output logic            mdc,
   output logic            mdio_wire
);
   timeunit 1ns;
   timeprecision 1ns;

   logic h_oe;
   logic h_bit;

   // Pull-up: a released line reads high, never the last driven bit
   assign mdio_wire = !mdio_oe_b ? mdio_out : (h_oe ? h_bit : 1'b1);

   initial begin
      mdc   = 1'b0;
      h_oe  = 1'b0;
      h_bit = 1'b1;
   end

   // Line sampled just before mdc rises, so a device bit has stood most of a period
   task automatic bit_cyc(input logic oe, input logic b, output logic smp);
      @(negedge sys_clk);
      mdc   = 1'b0;
      h_oe  = oe;
      h_bit = b;
      repeat (HALF - 1) @(negedge sys_clk);
      smp = mdio_wire;
      mdc = 1'b1;
      repeat (HALF - 1) @(negedge sys_clk);
   endtask : bit_cyc

   task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] wd,
                        output logic [15:0] rd, input logic [1:0] st = 2'b00);
      logic        s;
      logic        rdn;
      logic [13:0] hdr;
      rdn = op[1];
      hdr = {st, op, prtad, dev};
      repeat (32) bit_cyc(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
      bit_cyc(!rdn, 1'b1, s);
      bit_cyc(!rdn, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_cyc(!rdn, wd[i], s);
         rd[i] = s;
      end
      // Clock stands low between frames
      @(negedge sys_clk);
      mdc  = 1'b0;
      h_oe = 1'b0;
   endtask : frame
endmodule : pmr_host

// >>> sim/test_pmr_regs.sv
// Self-checking bench for the attachment-layer register bank with a reference model
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_pmr_regs
   import pmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [4:0] PRT   = 5'h03;
   localparam int         LIMIT = 80000;

   logic        sys_clk;
   logic        rst_b;
   logic        mdc;
   logic        mdio_in;
   logic        mdio_out;
   logic        mdio_oe_b;
   logic        strap;
   logic        link_ok;
   logic [3:0]  tx_nibble;
   logic [3:0]  line_rx_nibble;
   logic [3:0]  rx_nibble;
   logic        soft_power_down;
   logic        loopback;
   logic [6:0]  type_sel;
   logic        chip_reset_active;
   logic [15:0] d;
   logic [31:0] seed;
   int          failures;
   int          n_compared;
   int          cyc;
   int          rst_cnt;
   int          link_ll;
   int          mdl[8];

   pmr_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe_b(mdio_oe_b), .port_addr(PRT), .power_down_strap_pin(strap), .link_ok(link_ok),
      .tx_nibble(tx_nibble), .line_rx_nibble(line_rx_nibble), .rx_nibble(rx_nibble),
      .soft_power_down(soft_power_down), .local_loopback_enable(loopback),
      .attachment_type_select(type_sel), .chip_reset_active(chip_reset_active));

   pmr_host #(.HALF(6)) host (.sys_clk(sys_clk), .prtad(PRT), .mdio_out(mdio_out),
      .mdio_oe_b(mdio_oe_b), .mdc(mdc), .mdio_wire(mdio_in));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         results();
      end
   end

   // Sampled off the active edge so the busy flop has settled
   always @(negedge sys_clk) begin
      if (chip_reset_active === 1'b1) rst_cnt++;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [15:0] exp_rd(input int a);
      case (a)
         0: return 16'(mdl[0]);
         1: return 16'(32'h2 | (link_ll << 2));
         5: return 16'h008B;
         6: return 16'hC000;
         7: return 16'(mdl[7]);
         default: return 16'h0000;
      endcase
   endfunction : exp_rd

   task automatic wr(input int a, input logic [15:0] v);
      host.frame(OP_ADDR, MMD_PMA, 16'(a), d);
      host.frame(OP_WRITE, MMD_PMA, v, d);
      if (a == 0) mdl[0] = v & 16'h0801;
      if (a == 7) mdl[7] = v & 16'h007F;
   endtask : wr

   task automatic chk_rd(input int a);
      host.frame(OP_ADDR, MMD_PMA, 16'(a), d);
      host.frame(OP_READ, MMD_PMA, 16'h0000, d);
      `CHK(d, exp_rd(a))
      if (a == 1) link_ll = int'(link_ok);
   endtask : chk_rd

   task automatic chk_rx();
      logic [3:0] e;
      tx_nibble = 4'(rnd());
      line_rx_nibble = 4'(rnd());
      @(negedge sys_clk);
      @(negedge sys_clk);
      e = (mdl[0] & 'h800) ? 4'h0 : ((mdl[0] & 1) ? tx_nibble : line_rx_nibble);
      `CHK(rx_nibble, e)
      `CHK(soft_power_down, 1'(mdl[0] >> 11))
      `CHK(loopback, 1'(mdl[0]))
   endtask : chk_rx

   task automatic results();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   initial begin
      rst_b = 1'b0;
      strap = 1'b1;
      link_ok = 1'b1;
      tx_nibble = 4'h0;
      line_rx_nibble = 4'h0;
      failures = 0;
      n_compared = 0;
      cyc = 0;
      rst_cnt = 0;
      link_ll = 0;
      seed = 32'd43;
      mdl = '{default: 0};
      repeat (8) @(negedge sys_clk);
      rst_b = 1'b1;
      mdl[0] = 'h0800;
      mdl[7] = 'h3D;
      @(negedge sys_clk);
      @(negedge sys_clk);
      `CHK(soft_power_down, 1'b1)
      chk_rd(0);
      chk_rd(1);
      chk_rd(1);
      // One-cycle link glitch must still be caught by the latch
      link_ok = 1'b0;
      link_ll = 0;
      @(negedge sys_clk);
      link_ok = 1'b1;
      chk_rd(1);
      chk_rd(1);
      host.frame(OP_ADDR, MMD_PMA, 16'h0005, d);
      for (int a = 5; a <= 7; a++) begin
         host.frame(OP_RDINC, MMD_PMA, 16'h0000, d);
         `CHK(d, exp_rd(a))
      end
      for (int i = 0; i < 4; i++) begin
         wr(0, i == 0 ? 16'h0001 : i == 1 ? 16'h0000 : i == 2 ? 16'h0800 : 16'h7FFF);
         chk_rx();
         chk_rd(0);
      end
      wr(7, 16'(rnd()));
      chk_rd(7);
      `CHK(type_sel, 7'(mdl[7]))
      wr(5, 16'(rnd()));
      chk_rd(5);
      wr(3, 16'hFFFF);
      chk_rd(3);
      // Foreign device address: ignored, line left to the pull-up
      host.frame(OP_WRITE, 5'h1E, 16'h0000, d);
      host.frame(OP_READ, 5'h1E, 16'h0000, d);
      `CHK(d, 16'hFFFF)
      // Clause 22 start code: the write below must be dropped
      host.frame(OP_ADDR, MMD_PMA, 16'h0000, d);
      host.frame(OP_WRITE, MMD_PMA, 16'h0000, d, 2'b01);
      chk_rd(0);
      strap = 1'b0;
      rst_cnt = 0;
      wr(0, 16'h8801);
      host.frame(OP_READ, MMD_PMA, 16'h0000, d);
      `CHK(d[15], 1'b1)
      for (int i = 0; i < 2000 && chip_reset_active !== 1'b0; i++) @(negedge sys_clk);
      `CHK(rst_cnt, SOFT_RST_CYC)
      mdl[0] = 0;
      mdl[7] = 'h3D;
      chk_rd(0);
      chk_rd(7);
      `CHK(type_sel, 7'h3D)
      results();
   end
endmodule : test_pmr_regs
